// File: rtl/lookahead_rx_descriptor_parser.sv
`timescale 1ns/1ps
`include "lookahead_packet_processing_regs.svh"
module lookahead_rx_descriptor_parser
  import lookahead_packet_processing_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Avalon-MM slave
  input wire logic [8:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Received byte stream
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_DATA_I,
  input wire logic RX_LAST_I,
  input wire logic RX_ERR_I,
  input wire logic RX_HAVE64_I,
  output logic RX_READY_O,
  // Buffer byte writes
  output logic DMA_VALID_O,
  output logic [7:0] DMA_DATA_O,
  output logic [3:0] DMA_DESC_O,
  output logic [15:0] DMA_OFFSET_O,
  input wire logic DMA_READY_I,
  // Events
  output logic START_PACKET_O,
  output logic FRAME_DONE_O
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  desc_port_if dport ();
  eng_state_e st_q, st_d;
  ring_idx_t cur_q, nxt;
  desc_word_t rd;
  logic [15:0] size_q, next_size_q, cnt_q;
  logic first_q, next_own_q, done_q, err_q, eof_q;
  logic run_q, lookahead_processing_enable_q, pend_q, rd_mem_q, sp_q, fd_q;
  logic [31:0] csr_rd_q;
  logic dma_valid_q;
  logic [7:0] dma_data_q;
  logic [3:0] dma_desc_q;
  logic [15:0] dma_ofs_q;
  logic receive_interrupt_flag, buffer_error_flag;

  // ----------------------------------------------------------------
  // Engine decode
  // ----------------------------------------------------------------
  assign rd = dport.rdata;
  assign nxt = (cur_q == `LOOKAHEAD_PACKET_PROCESSING_LAST_IDX) ? 4'h0 : cur_q + 4'h1;
  wire start_ok = rd[`D_OWN] & (rd[`D_STP] | ~lookahead_processing_enable_q);
  wire disc = (st_q == SEEK_EV) & run_q & lookahead_processing_enable_q & rd[`D_OWN] & ~rd[`D_STP];
  // Unowned non-start entries are passed by only here, in the search.
  wire skip = (st_q == SEEK_EV) & run_q & lookahead_processing_enable_q & ~rd[`D_OWN] & ~rd[`D_STP];
  // Status may not overtake the last data byte still waiting at the buffer port.
  wire wr_go = (st_q == WR_CUR) & ~dma_valid_q;
  wire rx_take = (st_q == MOVE) & RX_VALID_I & RX_READY_O;
  wire full = (cnt_q + 16'h0001) >= size_q;
  wire eng_rd = (st_q == SEEK_RD) | (st_q == LOOK_RD) | (st_q == DITCH_RD);
  wire eng_req = eng_rd | disc | wr_go;
  wire eng_we = disc | wr_go;
  wire [3:0] eng_addr = ((st_q == LOOK_RD) | (st_q == DITCH_RD)) ? nxt : cur_q;
  // Discarding zeroes owner, start and end, which covers the second and third of a group.
  wire [31:0] disc_word = {3'b000, rd[28:0]};
  wire [31:0] stat_word = {1'b0, first_q, done_q & ~err_q, err_q, cnt_q[11:0], size_q};
  wire ditch_fail = (st_q == DITCH_EV) & ~rd[`D_OWN];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire sel_ctrl = AVS_ADDRESS_I == `LOOKAHEAD_PACKET_PROCESSING_CTRL_OFS;
  wire sel_stat = AVS_ADDRESS_I == `LOOKAHEAD_PACKET_PROCESSING_STAT_OFS;
  wire [8:0] desc_base = `LOOKAHEAD_PACKET_PROCESSING_DESC_BASE;
  wire sel_desc = (AVS_ADDRESS_I[8:6] == desc_base[8:6]) & (AVS_ADDRESS_I[1:0] == 2'h0);
  // The engine always has the descriptor port first; the bus waits for a free cycle.
  wire grant = (AVS_READ_I | AVS_WRITE_I) & ~pend_q & ~eng_req;
  wire wr_ok = grant & AVS_WRITE_I;
  wire ctrl_wr = wr_ok & sel_ctrl & AVS_BYTEENABLE_I[0];
  wire stat_clr = wr_ok & sel_stat & AVS_BYTEENABLE_I[0];
  wire [31:0] csr_val = sel_ctrl ? {26'h0, lookahead_processing_enable_q, 4'h0, run_q} :
                        sel_stat ? {20'h0, cur_q, 6'h0, buffer_error_flag, receive_interrupt_flag} : 32'h0;

  assign dport.en = eng_req | (grant & sel_desc);
  assign dport.we = eng_req ? eng_we : (AVS_WRITE_I & (AVS_BYTEENABLE_I == 4'hF));
  assign dport.addr = eng_req ? eng_addr : AVS_ADDRESS_I[5:2];
  assign dport.wdata = eng_req ? (disc ? disc_word : stat_word) : AVS_WRITEDATA_I;
  assign AVS_WAITREQUEST_O = ~(wr_ok | pend_q);
  assign AVS_READDATA_O = rd_mem_q ? rd : csr_rd_q;

  desc_mem #(.DEPTH(`LOOKAHEAD_PACKET_PROCESSING_RING_LEN)) u_mem (
    .clk_i(CLK_I),
    .port(dport)
  );

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  sticky_flag u_receive_interrupt_flag (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .set_i(wr_go & ((first_q & lookahead_processing_enable_q) | done_q)),
    .clr_i(stat_clr & AVS_WRITEDATA_I[`LOOKAHEAD_PACKET_PROCESSING_RECEIVE_INTERRUPT_FLAG_BIT]),
    .flag_o(receive_interrupt_flag)
  );

  sticky_flag u_buffer_error_flag (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .set_i(ditch_fail),
    .clr_i(stat_clr & AVS_WRITEDATA_I[`LOOKAHEAD_PACKET_PROCESSING_BUFFER_ERROR_FLAG_BIT]),
    .flag_o(buffer_error_flag)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      IDLE: if (run_q) st_d = SEEK_RD;
      SEEK_RD: st_d = SEEK_EV;
      SEEK_EV: begin
        if (!run_q) st_d = IDLE;
        else if (start_ok) st_d = WAIT_64;
        else st_d = SEEK_RD;
      end
      WAIT_64: if (RX_HAVE64_I) st_d = LOOK_RD;
      LOOK_RD: st_d = LOOK_EV;
      LOOK_EV: st_d = MOVE;
      MOVE: begin
        if (rx_take && (RX_LAST_I || (full && next_own_q))) st_d = WR_CUR;
        else if (rx_take && full) st_d = DITCH_RD;
      end
      DITCH_RD: st_d = DITCH_EV;
      DITCH_EV: st_d = WR_CUR;
      WR_CUR: begin
        if (wr_go && !done_q) st_d = LOOK_RD;
        else if (wr_go && err_q && !eof_q) st_d = DRAIN;
        else if (wr_go) st_d = SEEK_RD;
      end
      DRAIN: if (RX_VALID_I && RX_LAST_I) st_d = SEEK_RD;
      default: st_d = IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Engine registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      st_q <= IDLE;
      cur_q <= 4'h0;
    end else begin
      st_q <= st_d;
      if (disc || skip || wr_go) begin
        cur_q <= nxt;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      size_q <= 16'h0000;
      next_size_q <= 16'h0000;
      cnt_q <= 16'h0000;
      first_q <= 1'b0;
      next_own_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      eof_q <= 1'b0;
    end else begin
      if (st_q == SEEK_EV && start_ok) begin
        size_q <= rd[15:0];
        cnt_q <= 16'h0000;
        first_q <= 1'b1;
        done_q <= 1'b0;
        err_q <= 1'b0;
        eof_q <= 1'b0;
      end
      if (st_q == LOOK_EV) begin
        next_own_q <= rd[`D_OWN];
        next_size_q <= rd[15:0];
      end
      if (st_q == DITCH_EV) begin
        next_own_q <= rd[`D_OWN];
        next_size_q <= rd[15:0];
        done_q <= ~rd[`D_OWN];
        err_q <= ~rd[`D_OWN];
      end
      if (rx_take) begin
        cnt_q <= cnt_q + 16'h0001;
        done_q <= RX_LAST_I;
        err_q <= RX_LAST_I & RX_ERR_I;
        eof_q <= RX_LAST_I;
      end
      if (wr_go && !done_q) begin
        size_q <= next_size_q;
        cnt_q <= 16'h0000;
        first_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Byte path and events
  // ----------------------------------------------------------------
  assign RX_READY_O = ((st_q == MOVE) & (~dma_valid_q | DMA_READY_I)) | (st_q == DRAIN);

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      dma_valid_q <= 1'b0;
      dma_data_q <= 8'h00;
      dma_desc_q <= 4'h0;
      dma_ofs_q <= 16'h0000;
      sp_q <= 1'b0;
      fd_q <= 1'b0;
    end else begin
      if (rx_take) begin
        dma_valid_q <= 1'b1;
        dma_data_q <= RX_DATA_I;
        dma_desc_q <= cur_q;
        dma_ofs_q <= cnt_q;
      end else if (DMA_READY_I) begin
        dma_valid_q <= 1'b0;
      end
      sp_q <= wr_go & first_q & lookahead_processing_enable_q;
      fd_q <= wr_go & done_q;
    end
  end

  assign DMA_VALID_O = dma_valid_q;
  assign DMA_DATA_O = dma_data_q;
  assign DMA_DESC_O = dma_desc_q;
  assign DMA_OFFSET_O = dma_ofs_q;
  assign START_PACKET_O = sp_q;
  assign FRAME_DONE_O = fd_q;

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      run_q <= `LOOKAHEAD_PACKET_PROCESSING_RUN_RST;
      lookahead_processing_enable_q <= `LOOKAHEAD_PACKET_PROCESSING_EN_RST;
      pend_q <= 1'b0;
      rd_mem_q <= 1'b0;
      csr_rd_q <= 32'h0000_0000;
    end else begin
      pend_q <= grant & AVS_READ_I;
      if (grant && AVS_READ_I) begin
        rd_mem_q <= sel_desc;
        csr_rd_q <= csr_val;
      end
      if (ctrl_wr) begin
        run_q <= AVS_WRITEDATA_I[`LOOKAHEAD_PACKET_PROCESSING_RUN_BIT];
        lookahead_processing_enable_q <= AVS_WRITEDATA_I[`LOOKAHEAD_PACKET_PROCESSING_EN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_start_owned;
    @(posedge CLK_I) disable iff (RESET_I)
    (st_q == SEEK_EV && run_q && lookahead_processing_enable_q && st_d == WAIT_64) |-> (rd[`D_OWN] && rd[`D_STP]);
  endproperty
  a_start_owned: assert property (p_start_owned) else $error("frame began in bad slot");

  property p_chain_owned;
    @(posedge CLK_I) disable iff (RESET_I)
    (wr_go && !done_q) |-> next_own_q;
  endproperty
  a_chain_owned: assert property (p_chain_owned) else $error("chained into unowned slot");

  property p_frame_marked;
    @(posedge CLK_I) disable iff (RESET_I)
    (wr_go && done_q) |-> (dport.we && (dport.wdata[`D_END] ^ dport.wdata[`D_ERR]));
  endproperty
  a_frame_marked: assert property (p_frame_marked) else $error("frame end not marked");

  property p_discard;
    @(posedge CLK_I) disable iff (RESET_I)
    disc |-> (dport.we && !dport.wdata[`D_OWN] && !dport.wdata[`D_END]) ##1 (st_q == SEEK_RD);
  endproperty
  a_discard: assert property (p_discard) else $error("discard wrong");

  property p_skip;
    @(posedge CLK_I) disable iff (RESET_I)
    (skip && !AVS_WRITE_I) |-> !dport.we ##1 (st_q == SEEK_RD && cur_q == $past(nxt));
  endproperty
  a_skip: assert property (p_skip) else $error("skip wrong");

  property p_look;
    @(posedge CLK_I) disable iff (RESET_I)
    (st_q == WAIT_64 && RX_HAVE64_I) |=> (st_q == LOOK_RD && dport.en && !dport.we)
      ##1 (st_q == LOOK_EV) ##1 (st_q == MOVE);
  endproperty
  a_look: assert property (p_look) else $error("look-ahead sequence broken");

  property p_buffer_error_flag;
    @(posedge CLK_I) disable iff (RESET_I)
    ditch_fail |=> (buffer_error_flag && st_q == WR_CUR && done_q && err_q);
  endproperty
  a_buffer_error_flag: assert property (p_buffer_error_flag) else $error("buffer error not flagged");

  property p_middle;
    @(posedge CLK_I) disable iff (RESET_I)
    (wr_go && !done_q) |-> (!dport.wdata[`D_OWN] && !dport.wdata[`D_END])
      ##1 (cur_q == $past(nxt) && st_q == LOOK_RD);
  endproperty
  a_middle: assert property (p_middle) else $error("middle status wrong");

  property p_srp;
    @(posedge CLK_I) disable iff (RESET_I)
    (wr_go && first_q && lookahead_processing_enable_q) |=> (START_PACKET_O && receive_interrupt_flag);
  endproperty
  a_srp: assert property (p_srp) else $error("start interrupt missing");

  property p_wrap;
    @(posedge CLK_I) disable iff (RESET_I)
    ((disc || skip) && cur_q == `LOOKAHEAD_PACKET_PROCESSING_LAST_IDX) |=> (cur_q == 4'h0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("ring did not wrap");
endmodule // lookahead_rx_descriptor_parser

// File: rtl/lookahead_packet_processing_regs.svh
// What this block does
// - With look-ahead on, a frame begins only where owner and start are both 1.
// - A frame chains into the next buffer only when the block owns it.
// - Every frame ends with end or error set in its last written descriptor.
// - In the search, owned non-start descriptors are discarded by clearing owner, start and end.
// - In the search only, unowned non-start descriptors are stepped past.
// - A returned third descriptor after a frame ends in buffer two gets owner, start and end zeroed.
// - A still unowned third descriptor is skipped and its end flag is left alone.
// - A short frame ends in buffer one; the second descriptor is discarded, end zero.
// - Look-ahead enable is bit 5 of control register three.
// - With look-ahead on, writing a start descriptor's status raises the receive flag.
// - At the 64th byte data moves to buffer one and the next descriptor is read.
// - Data left and the next descriptor still host-owned at last look gives buffer error.
`ifndef LOOKAHEAD_PACKET_PROCESSING_REGS_SVH
`define LOOKAHEAD_PACKET_PROCESSING_REGS_SVH
`define LOOKAHEAD_PACKET_PROCESSING_CTRL_OFS 9'h000
`define LOOKAHEAD_PACKET_PROCESSING_STAT_OFS 9'h004
`define LOOKAHEAD_PACKET_PROCESSING_DESC_BASE 9'h100
`define LOOKAHEAD_PACKET_PROCESSING_RING_LEN 16
`define LOOKAHEAD_PACKET_PROCESSING_LAST_IDX 4'hF
`define LOOKAHEAD_PACKET_PROCESSING_RUN_BIT 0
`define LOOKAHEAD_PACKET_PROCESSING_EN_BIT 5
`define LOOKAHEAD_PACKET_PROCESSING_RECEIVE_INTERRUPT_FLAG_BIT 0
`define LOOKAHEAD_PACKET_PROCESSING_BUFFER_ERROR_FLAG_BIT 1
`define LOOKAHEAD_PACKET_PROCESSING_RUN_RST 1'h0
`define LOOKAHEAD_PACKET_PROCESSING_EN_RST 1'h0
`define D_OWN 31
`define D_STP 30
`define D_END 29
`define D_ERR 28
`define LOOKAHEAD_PACKET_PROCESSING_LOOK_BYTES 16'h0040
`endif

// File: rtl/lookahead_packet_processing_pkg.sv
package lookahead_packet_processing_pkg;
  typedef enum logic [3:0] {
    IDLE, SEEK_RD, SEEK_EV, WAIT_64, LOOK_RD, LOOK_EV, MOVE, DITCH_RD, DITCH_EV, WR_CUR, DRAIN
  } eng_state_e;
  typedef logic [31:0] desc_word_t;
  typedef logic [3:0] ring_idx_t;
endpackage

// File: rtl/desc_port_if.sv
`timescale 1ns/1ps
interface desc_port_if;
  logic en;
  logic we;
  logic [3:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport user (output en, output we, output addr, output wdata, input rdata);
  modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface

// File: rtl/desc_mem.sv
`timescale 1ns/1ps
module desc_mem #(
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  desc_port_if.mem port
);
  logic [31:0] mem_q [DEPTH];
  logic [31:0] rdata_q;

  // Read data stays in its register until the next read, so a later caller may use it.
  always_ff @(posedge clk_i) begin
    if (port.en && port.we) begin
      mem_q[port.addr] <= port.wdata;
    end
    if (port.en && !port.we) begin
      rdata_q <= mem_q[port.addr];
    end
  end

  assign port.rdata = rdata_q;
endmodule // desc_mem

// File: rtl/sticky_flag.sv
`timescale 1ns/1ps
module sticky_flag (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  logic flag_q;

  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= set_i | (flag_q & ~clr_i);
    end
  end

  assign flag_o = flag_q;
endmodule // sticky_flag

// File: testbench/dma_sink.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Buffer memory side: accepts bytes but stalls one beat in four.
// ----------------------------------------------------------------
module dma_sink (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Byte handshake
  input wire logic valid_i,
  output logic ready_o
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;

  // The stall pattern moves only with traffic, so every byte position sees a stall.
  assign cnt_d = valid_i ? cnt_q + 2'h1 : cnt_q;
  assign ready_o = (cnt_q != 2'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // dma_sink

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import lookahead_packet_processing_pkg::*;
  logic CLK_I;
  logic RESET_I;
  logic avs_read;
  logic avs_write;
  logic avs_wait;
  logic [8:0] avs_addr;
  logic [31:0] avs_wdata;
  logic [31:0] avs_rdata;
  logic [31:0] rd;
  logic rx_valid;
  logic rx_last;
  logic rx_err;
  logic rx_have;
  logic rx_ready;
  logic [7:0] rx_data;
  logic [7:0] lf;
  logic dma_valid;
  logic dma_ready;
  logic [7:0] dma_data;
  logic [3:0] dma_desc;
  logic [15:0] dma_ofs;
  logic start_pkt;
  logic frame_done;
  logic [27:0] exp_q[$];
  int error_cnt;
  int tests_run;
  int starts;
  int dones;

  initial begin
    CLK_I = 1'h0;
    forever #4 CLK_I = ~CLK_I;
  end

  lookahead_rx_descriptor_parser lookahead_rx_descriptor_parser_inst (
    .CLK_I(CLK_I), .RESET_I(RESET_I), .AVS_ADDRESS_I(avs_addr), .AVS_READ_I(avs_read),
    .AVS_WRITE_I(avs_write), .AVS_WRITEDATA_I(avs_wdata), .AVS_BYTEENABLE_I(4'hF),
    .AVS_READDATA_O(avs_rdata), .AVS_WAITREQUEST_O(avs_wait), .RX_VALID_I(rx_valid),
    .RX_DATA_I(rx_data), .RX_LAST_I(rx_last), .RX_ERR_I(rx_err), .RX_HAVE64_I(rx_have),
    .RX_READY_O(rx_ready), .DMA_VALID_O(dma_valid), .DMA_DATA_O(dma_data),
    .DMA_DESC_O(dma_desc), .DMA_OFFSET_O(dma_ofs), .DMA_READY_I(dma_ready),
    .START_PACKET_O(start_pkt), .FRAME_DONE_O(frame_done));

  dma_sink dma_sink_inst (.clk_i(CLK_I), .rst_i(RESET_I), .valid_i(dma_valid),
    .ready_o(dma_ready));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  function automatic logic [8:0] da(input logic [3:0] i);
    return {3'h4, i, 2'h0};
  endfunction

  // Slot 2 starts owned as if returned early; 5 holds a stale end flag.
  // Every buffer holds four bytes, a fixed size with no tuning.
  function automatic logic [31:0] init_w(input int i);
    if (i == 2 || i == 15) return 32'h8000_0004;
    if (i == 5) return 32'h2000_0004;
    if (i == 12 || i == 13) return 32'h0000_0004;
    if (i % 3 == 0) return 32'hC000_0004;
    if (i % 3 == 1) return 32'h8000_0004;
    return 32'h0000_0004;
  endfunction

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic note(input string n);
    $display("test %s finished", n);
  endtask

  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK_I);
    avs_addr <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_wdata <= d;
    do begin
      @(posedge CLK_I);
      n++;
    end while (avs_wait !== 1'h0 && n < 200);
    if (avs_wait !== 1'h0) begin
      error_cnt++;
      end_sim();
    end
    rd = avs_rdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask

  task automatic chk(input logic [3:0] i, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF);
    bus(1'h0, da(i), 32'h0);
    cmp("descriptor", e, rd & m);
  endtask

  // Bytes of buffer b land in slot s+b at offset k mod 4, since every size is 4 except slot 6's 8 at the end, which a 2-byte frame never fills.
  // Only the first m bytes reach a buffer; the rest of a cut frame is drained.
  task automatic frame(input logic [3:0] s, input int n, input logic e, input int m = 64);
    int k;
    int t;
    int d0;
    d0 = dones;
    @(posedge CLK_I);
    rx_have <= 1'h1;
    for (k = 0; k < n; k++) begin
      lf = lfsr(lf);
      rx_valid <= 1'h1;
      rx_data <= lf;
      rx_last <= (k == n - 1);
      rx_err <= e && (k == n - 1);
      if (k < m) exp_q.push_back({s + 4'(k / 4), 16'(k % 4), lf});
      t = 0;
      do begin
        @(posedge CLK_I);
        t++;
      end while (rx_ready !== 1'h1 && t < 300);
      if (rx_ready !== 1'h1) begin
        error_cnt++;
        end_sim();
      end
    end
    rx_valid <= 1'h0;
    rx_last <= 1'h0;
    rx_err <= 1'h0;
    rx_have <= 1'h0;
    t = 0;
    while (dones == d0 && t < 300) begin
      @(posedge CLK_I);
      t++;
    end
    if (dones == d0) begin
      error_cnt++;
      end_sim();
    end
  endtask

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (start_pkt === 1'h1) starts++;
    if (frame_done === 1'h1) dones++;
    if (dma_valid === 1'h1 && dma_ready === 1'h1) begin
      if (exp_q.size() == 0) cmp("dma_extra", 32'h0, 32'h1);
      else cmp("dma", {4'h0, exp_q.pop_front()}, {4'h0, dma_desc, dma_ofs, dma_data});
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    error_cnt = 0;
    tests_run = 0;
    starts = 0;
    dones = 0;
    lf = 8'h07;
    RESET_I = 1'h1;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_addr = 9'h000;
    avs_wdata = 32'h0;
    rx_valid = 1'h0;
    rx_data = 8'h00;
    rx_last = 1'h0;
    rx_err = 1'h0;
    rx_have = 1'h0;
    repeat (20) @(posedge CLK_I);
    RESET_I <= 1'h0;
    bus(1'h0, 9'h000, 32'h0);
    cmp("ctrl_reset", 32'h0, rd & 32'h21);
    bus(1'h0, 9'h008, 32'h0);
    cmp("unmapped", 32'h0, rd);
    for (int i = 0; i < 16; i++) bus(1'h1, da(4'(i)), init_w(i));
    bus(1'h1, 9'h000, 32'h21);
    bus(1'h0, 9'h000, 32'h0);
    cmp("ctrl", 32'h21, rd & 32'h21);
    note("setup");
    frame(4'h0, 10, 1'h0);
    chk(4'h0, 32'h4004_0004);
    chk(4'h1, 32'h0004_0004);
    chk(4'h2, 32'h2002_0004);
    note("three_buffers");
    frame(4'h3, 6, 1'h0);
    chk(4'h4, 32'h2002_0004);
    chk(4'h5, 32'h2000_0004);
    note("third_not_returned");
    frame(4'h6, 2, 1'h0);
    chk(4'h6, 32'h6002_0004);
    chk(4'h7, 32'h0000_0004);
    note("short_frame");
    frame(4'h9, 5, 1'h1);
    chk(4'hA, 32'h1000_0000, 32'h9000_0000);
    note("error_frame");
    // Slot 15, the non-start slot before slot 0, is already owned by the block here.
    bus(1'h1, da(4'h0), 32'hC000_0004);
    bus(1'h1, da(4'h1), 32'h8000_0004);
    bus(1'h1, da(4'h2), 32'h8000_0004);
    frame(4'h0, 6, 1'h0);
    chk(4'hF, 32'h0000_0004);
    chk(4'h0, 32'h4004_0004);
    chk(4'h1, 32'h2002_0004);
    chk(4'h2, 32'h0000_0004);
    note("wrap_and_returned_third");
    cmp("start_packet", 32'd5, 32'(starts));
    cmp("frame_done", 32'd5, 32'(dones));
    bus(1'h0, 9'h004, 32'h0);
    cmp("status", 32'h1, rd & 32'h3);
    note("events");
    // Slot 3 is handed back as a start; slot 4 stays host-owned, so the chain must fail.
    bus(1'h1, da(4'h3), 32'hC000_0004);
    frame(4'h3, 6, 1'h0, 4);
    chk(4'h3, 32'h5004_0004);
    chk(4'h4, 32'h2002_0004);
    cmp("buffer_error_done", 32'd6, 32'(dones));
    note("buffer_error");
    // With look-ahead off, an owned slot starts a frame even without its start flag.
    bus(1'h1, 9'h000, 32'h01);
    bus(1'h1, da(4'h6), 32'h8000_0008);
    frame(4'h6, 2, 1'h0);
    chk(4'h6, 32'h6002_0008);
    cmp("start_packet_off", 32'd6, 32'(starts));
    cmp("frame_done_off", 32'd7, 32'(dones));
    bus(1'h0, 9'h004, 32'h0);
    cmp("status_flags", 32'h0000_0703, rd & 32'h0000_0F03);
    bus(1'h1, 9'h004, 32'h3);
    bus(1'h0, 9'h004, 32'h0);
    cmp("status_clear", 32'h0000_0700, rd & 32'h0000_0F03);
    note("lookahead_off");
    end_sim();
  end
endmodule // tb_top
